/* pit_pkg.sv */
// package: register map, field layout, reset values and carriers
package pit_pkg;

    // register offsets on the four select lines
    localparam logic [3:0] OFF_PORT_A_DATA = 4'h0;
    localparam logic [3:0] OFF_PORT_B_DATA = 4'h1;
    localparam logic [3:0] OFF_PORT_A_DIR  = 4'h2;
    localparam logic [3:0] OFF_PORT_B_DIR  = 4'h3;
    localparam logic [3:0] OFF_TIMER_A_LOW_BYTE       = 4'h4;
    localparam logic [3:0] OFF_TIMER_A_HIGH_BYTE       = 4'h5;
    localparam logic [3:0] OFF_TIMER_B_LOW_BYTE       = 4'h6;
    localparam logic [3:0] OFF_TIMER_B_HIGH_BYTE       = 4'h7;
    localparam logic [3:0] OFF_INT_CTRL    = 4'hd;
    localparam logic [3:0] OFF_TA_CTRL     = 4'he;
    localparam logic [3:0] OFF_TB_CTRL     = 4'hf;

    // timer control register bit positions
    localparam int CTL_START    = 0;
    localparam int CTL_PB_ON    = 1;
    localparam int CTL_TOGGLE   = 2;
    localparam int CTL_ONE_SHOT = 3;
    localparam int CTL_LOAD     = 4;
    localparam int CTL_IN_LO    = 5;
    localparam int CTL_IN_HI    = 6;

    // interrupt control layout
    localparam int INT_TA     = 0;
    localparam int INT_TB     = 1;
    localparam int INT_EDGE   = 4;
    localparam int INT_SETCLR = 7;
    localparam int INT_NSRC   = 5;

    // port b lines that carry the timer outputs
    localparam int PB_TA_LINE = 6;
    localparam int PB_TB_LINE = 7;

    // reset values
    localparam logic [7:0]  RST_BYTE  = 8'h00;
    localparam logic [15:0] RST_LATCH = 16'hffff;
    localparam logic [15:0] RST_COUNT = 16'h0000;
    localparam logic [4:0]  RST_INT   = 5'h00;

    // timer b count source codes
    localparam logic [1:0] TB_SRC_BUS  = 2'h0;
    localparam logic [1:0] TB_SRC_CNT  = 2'h1;
    localparam logic [1:0] TB_SRC_TA   = 2'h2;
    localparam logic [1:0] TB_SRC_TACN = 2'h3;

    // one sample of the host bus pins
    typedef struct packed {
        logic       phi2;
        logic       selN;
        logic       rw;
        logic [3:0] regSel;
        logic [7:0] data;
    } pit_bus_t;

endpackage

/* pit_top.sv */
// design: ports, interval timers and host bus decode
`timescale 1ns/100ps

// two-stage synchroniser for pin inputs
module pit_sync #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             rstN,
    // level in and synchronised level out
    input  wire logic [WIDTH-1:0] din,
    output logic      [WIDTH-1:0] dout
);
    logic [WIDTH-1:0] meta;   // first stage, read only by second

    // two flip-flops in series
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            meta <= '0;
            dout <= '0;
        end else begin
            meta <= din;
            dout <= meta;
        end
    end
endmodule

// one interval timer with its latch and control register
module pit_timer (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rstN,
    // register writes from the bus decode
    input  wire logic        latchLoWr,
    input  wire logic        latchHiWr,
    input  wire logic        ctrlWr,
    input  wire logic [7:0]  wrData,
    // count source and bus cycle tick
    input  wire logic        countEn,
    input  wire logic        busTick,
    // state seen by the rest of the device
    output logic [15:0]      count,
    output logic [7:0]       ctrlRead,
    output logic             underflow,
    output logic             outLevel
);
    logic [15:0] latch;       // write-only reload value
    logic [7:0]  ctrl;        // stored control bits, strobe kept zero
    logic        toggleOut;   // toggle-mode output level
    logic        pulseOut;    // pulse-mode output level
    logic        forceLoad;   // strobe written as one
    logic        startRise;   // start written while stopped
    logic        running;     // start bit state

    assign running   = ctrl[pit_pkg::CTL_START];
    assign forceLoad = ctrlWr & wrData[pit_pkg::CTL_LOAD];
    assign startRise = ctrlWr & wrData[pit_pkg::CTL_START] & ~running;
    // underflow when a count step finds zero
    assign underflow = running & countEn & (count == 16'h0000);
    // strobe bit never stored, so it reads zero
    assign ctrlRead  = ctrl;

    // latch takes the low and high byte writes
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            latch <= pit_pkg::RST_LATCH;
        end else if (latchLoWr) begin
            latch[7:0] <= wrData;
        end else if (latchHiWr) begin
            latch[15:8] <= wrData;
        end
    end

    // control register, start cleared when a one-shot ends
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            ctrl <= pit_pkg::RST_BYTE;
        end else if (ctrlWr) begin
            ctrl <= wrData & ~(8'h01 << pit_pkg::CTL_LOAD);
        end else if (underflow && ctrl[pit_pkg::CTL_ONE_SHOT]) begin
            ctrl[pit_pkg::CTL_START] <= 1'b0;
        end
    end

    // counter: loads win over counting
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            count <= pit_pkg::RST_COUNT;
        end else if (forceLoad) begin
            count <= latch;
        end else if (latchHiWr && !running) begin
            // stopped: high byte write also reloads counter
            count <= {wrData, latch[7:0]};
        end else if (underflow) begin
            count <= latch;
        end else if (running && countEn) begin
            count <= count - 16'h0001;
        end
    end

    // toggle output: high on start, inverted per underflow
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            toggleOut <= 1'b0;
        end else if (startRise) begin
            toggleOut <= 1'b1;
        end else if (underflow) begin
            toggleOut <= ~toggleOut;
        end
    end

    // pulse output: high from underflow to next bus tick
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            pulseOut <= 1'b0;
        end else if (underflow) begin
            pulseOut <= 1'b1;
        end else if (busTick) begin
            pulseOut <= 1'b0;
        end
    end

    // select output form
    assign outLevel = ctrl[pit_pkg::CTL_TOGGLE] ? toggleOut : pulseOut;
endmodule

// top: host bus slave, two ports, two timers, interrupt flags
module pit_top (
    // clock and reset
    input  wire logic       sys_clk,
    input  wire logic       nrst,
    // host bus pins
    input  wire logic       phi2,
    input  wire logic       selN,
    input  wire logic       rw,
    input  wire logic [3:0] register_select,
    input  wire logic [7:0] hostDataIn,
    output logic      [7:0] hostDataOut,
    output logic            hostDataOe,
    // shared interrupt line, open drain
    output logic            irqOut,
    output logic            irqOe,
    // port a
    input  wire logic [7:0] portAIn,
    output logic      [7:0] portAOut,
    output logic      [7:0] portAOe,
    // port b and handshake
    input  wire logic [7:0] portBIn,
    output logic      [7:0] portBOut,
    output logic      [7:0] portBOe,
    output logic            port_b_strobe_n,
    input  wire logic       flagN,
    // external count pin
    input  wire logic       count_input
);
    logic [1:0]        rstPipe;    // reset release stages
    logic              rstN;       // released reset
    pit_pkg::pit_bus_t busRaw;     // bus pins as one word
    pit_pkg::pit_bus_t busS;       // synchronised bus
    pit_pkg::pit_bus_t busD;       // one cycle older bus
    logic [7:0]        portAS;     // synchronised port a pins
    logic [7:0]        portBS;     // synchronised port b pins
    logic [1:0]        pinS;       // synchronised count and flag
    logic [1:0]        pinD;       // delayed for edge detect
    logic              busTick;    // end of a bus clock high phase
    logic              access;     // selected access ends now
    logic              wrAcc;      // selected write
    logic              rdAcc;      // selected read
    logic [7:0]        portAData;  // port a data register
    logic [7:0]        portBData;  // port b data register
    logic [7:0]        portADir;   // port a direction
    logic [7:0]        portBDir;   // port b direction
    logic [15:0]       taCount;    // timer a counter
    logic [15:0]       tbCount;    // timer b counter
    logic [7:0]        taCtrl;     // timer a control readback
    logic [7:0]        tbCtrl;     // timer b control readback
    logic              taUnder;    // timer a underflow
    logic              tbUnder;    // timer b underflow
    logic              taOut;      // timer a output level
    logic              tbOut;      // timer b output level
    logic              taEn;       // timer a count step
    logic              tbEn;       // timer b count step
    logic              cntRise;    // count pin rising edge
    logic              flagFall;   // handshake falling edge
    logic [4:0]        intFlags;   // sticky interrupt flags
    logic [4:0]        intMask;    // interrupt enables
    logic [4:0]        intSet;     // flag set events
    logic              intPend;    // any enabled flag
    logic [7:0]        rdMux;      // selected register value
    logic [7:0]        next_portBOut; // port b line values
    logic [7:0]        next_portBOe;  // port b line enables

    // reset release through two flip-flops
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            rstPipe <= 2'b00;
        end else begin
            rstPipe <= {rstPipe[0], 1'b1};
        end
    end
    assign rstN = rstPipe[1];

    // pin synchronisers
    assign busRaw = '{phi2: phi2, selN: selN, rw: rw,
                      regSel: register_select, data: hostDataIn};
    pit_sync #(.WIDTH($bits(pit_pkg::pit_bus_t))) uBusSync (
        .clk  (sys_clk),
        .rstN (rstN),
        .din  (busRaw),
        .dout (busS)
    );
    pit_sync #(.WIDTH(16)) uPortSync (
        .clk  (sys_clk),
        .rstN (rstN),
        .din  ({portBIn, portAIn}),
        .dout ({portBS, portAS})
    );
    pit_sync #(.WIDTH(2)) uPinSync (
        .clk  (sys_clk),
        .rstN (rstN),
        .din  ({count_input, flagN}),
        .dout (pinS)
    );

    // bus and pin history for edge detection
    always_ff @(posedge sys_clk or negedge rstN) begin
        if (!rstN) begin
            busD <= '0;
            pinD <= 2'b00;   // same as synchroniser reset: no false fall
        end else begin
            busD <= busS;
            pinD <= pinS;
        end
    end

    // access taken as the high phase ends, with write data still valid
    assign busTick  = busD.phi2 & ~busS.phi2;
    assign access   = busTick & ~busD.selN;
    assign wrAcc    = access & ~busD.rw;
    assign rdAcc    = access & busD.rw;
    assign cntRise  = pinS[1] & ~pinD[1];
    assign flagFall = pinD[0] & ~pinS[0];

    // port data and direction registers
    always_ff @(posedge sys_clk or negedge rstN) begin
        if (!rstN) begin
            portAData <= pit_pkg::RST_BYTE;
            portBData <= pit_pkg::RST_BYTE;
            portADir  <= pit_pkg::RST_BYTE;
            portBDir  <= pit_pkg::RST_BYTE;
        end else if (wrAcc) begin
            unique case (busD.regSel)
                pit_pkg::OFF_PORT_A_DATA: portAData <= busD.data;
                pit_pkg::OFF_PORT_B_DATA: portBData <= busD.data;
                pit_pkg::OFF_PORT_A_DIR:  portADir  <= busD.data;
                pit_pkg::OFF_PORT_B_DIR:  portBDir  <= busD.data;
                default: ;                                    // other registers
            endcase
        end
    end

    // timer count sources
    assign taEn = taCtrl[pit_pkg::CTL_IN_LO] ? cntRise : busTick;
    always_comb begin
        unique case (tbCtrl[pit_pkg::CTL_IN_HI:pit_pkg::CTL_IN_LO])
            pit_pkg::TB_SRC_BUS:  tbEn = busTick;
            pit_pkg::TB_SRC_CNT:  tbEn = cntRise;
            pit_pkg::TB_SRC_TA:   tbEn = taUnder;
            pit_pkg::TB_SRC_TACN: tbEn = taUnder & pinS[1];
        endcase
    end

    // timer a, controlled by its own register
    pit_timer uTimerA (
        .clk       (sys_clk),
        .rstN      (rstN),
        .latchLoWr (wrAcc && busD.regSel == pit_pkg::OFF_TIMER_A_LOW_BYTE),
        .latchHiWr (wrAcc && busD.regSel == pit_pkg::OFF_TIMER_A_HIGH_BYTE),
        .ctrlWr    (wrAcc && busD.regSel == pit_pkg::OFF_TA_CTRL),
        .wrData    (busD.data),
        .countEn   (taEn),
        .busTick   (busTick),
        .count     (taCount),
        .ctrlRead  (taCtrl),
        .underflow (taUnder),
        .outLevel  (taOut)
    );

    // timer b, controlled by its own register
    pit_timer uTimerB (
        .clk       (sys_clk),
        .rstN      (rstN),
        .latchLoWr (wrAcc && busD.regSel == pit_pkg::OFF_TIMER_B_LOW_BYTE),
        .latchHiWr (wrAcc && busD.regSel == pit_pkg::OFF_TIMER_B_HIGH_BYTE),
        .ctrlWr    (wrAcc && busD.regSel == pit_pkg::OFF_TB_CTRL),
        .wrData    (busD.data),
        .countEn   (tbEn),
        .busTick   (busTick),
        .count     (tbCount),
        .ctrlRead  (tbCtrl),
        .underflow (tbUnder),
        .outLevel  (tbOut)
    );

    // interrupt flags: events set, reading clears, set wins
    always_comb begin
        intSet = '0;
        intSet[pit_pkg::INT_TA]   = taUnder;
        intSet[pit_pkg::INT_TB]   = tbUnder;
        intSet[pit_pkg::INT_EDGE] = flagFall;
    end
    always_ff @(posedge sys_clk or negedge rstN) begin
        if (!rstN) begin
            intFlags <= pit_pkg::RST_INT;
        end else if (rdAcc && busD.regSel == pit_pkg::OFF_INT_CTRL) begin
            intFlags <= intSet;
        end else begin
            intFlags <= intFlags | intSet;
        end
    end

    // mask register: bit seven chooses set or clear
    always_ff @(posedge sys_clk or negedge rstN) begin
        if (!rstN) begin
            intMask <= pit_pkg::RST_INT;
        end else if (wrAcc && busD.regSel == pit_pkg::OFF_INT_CTRL) begin
            if (busD.data[pit_pkg::INT_SETCLR]) begin
                intMask <= intMask | busD.data[4:0];
            end else begin
                intMask <= intMask & ~busD.data[4:0];
            end
        end
    end
    assign intPend = |(intFlags & intMask);

    // open-drain request: enable pulls low, output level fixed low
    always_ff @(posedge sys_clk or negedge rstN) begin
        if (!rstN) begin
            irqOut <= 1'b0;
            irqOe  <= 1'b0;
        end else begin
            irqOut <= 1'b0;
            irqOe  <= intPend;
        end
    end

    // read data selection
    always_comb begin
        unique case (busS.regSel)
            pit_pkg::OFF_PORT_A_DATA: rdMux = portAS;
            pit_pkg::OFF_PORT_B_DATA: rdMux = portBS;
            pit_pkg::OFF_PORT_A_DIR:  rdMux = portADir;
            pit_pkg::OFF_PORT_B_DIR:  rdMux = portBDir;
            pit_pkg::OFF_TIMER_A_LOW_BYTE:       rdMux = taCount[7:0];
            pit_pkg::OFF_TIMER_A_HIGH_BYTE:       rdMux = taCount[15:8];
            pit_pkg::OFF_TIMER_B_LOW_BYTE:       rdMux = tbCount[7:0];
            pit_pkg::OFF_TIMER_B_HIGH_BYTE:       rdMux = tbCount[15:8];
            pit_pkg::OFF_INT_CTRL:    rdMux = {intPend, 2'b00, intFlags};
            pit_pkg::OFF_TA_CTRL:     rdMux = taCtrl;
            pit_pkg::OFF_TB_CTRL:     rdMux = tbCtrl;
            default:                  rdMux = 8'h00;          // unused offsets 8 to c
        endcase
    end

    // host data drive only during a selected read high phase
    always_ff @(posedge sys_clk or negedge rstN) begin
        if (!rstN) begin
            hostDataOut <= 8'h00;
            hostDataOe  <= 1'b0;
        end else begin
            hostDataOut <= rdMux;
            hostDataOe  <= busS.phi2 & ~busS.selN & busS.rw;
        end
    end

    // port b strobe: low from the access to the next bus tick
    always_ff @(posedge sys_clk or negedge rstN) begin
        if (!rstN) begin
            port_b_strobe_n <= 1'b1;
        end else if (access && busD.regSel == pit_pkg::OFF_PORT_B_DATA) begin
            port_b_strobe_n <= 1'b0;
        end else if (busTick) begin
            port_b_strobe_n <= 1'b1;
        end
    end

    // port b lines with timer overrides
    always_comb begin
        next_portBOut = portBData;
        next_portBOe  = portBDir;
        if (taCtrl[pit_pkg::CTL_PB_ON]) begin
            next_portBOut[pit_pkg::PB_TA_LINE] = taOut;
            next_portBOe[pit_pkg::PB_TA_LINE]  = 1'b1;
        end
        if (tbCtrl[pit_pkg::CTL_PB_ON]) begin
            next_portBOut[pit_pkg::PB_TB_LINE] = tbOut;
            next_portBOe[pit_pkg::PB_TB_LINE]  = 1'b1;
        end
    end

    // port pin drivers, all inputs after reset
    always_ff @(posedge sys_clk or negedge rstN) begin
        if (!rstN) begin
            portAOut <= 8'h00;
            portAOe  <= 8'h00;
            portBOut <= 8'h00;
            portBOe  <= 8'h00;
        end else begin
            portAOut <= portAData;
            portAOe  <= portADir;
            portBOut <= next_portBOut;
            portBOe  <= next_portBOe;
        end
    end
endmodule

/* pit_props.sv */
// checker: bus, port, strobe and interrupt relations at the pins
`timescale 1ns/100ps
module pit_props (
    // clock and reset
    input wire logic       sys_clk,
    input wire logic       nrst,
    // host bus
    input wire logic       phi2,
    input wire logic       selN,
    input wire logic       rw,
    input wire logic [3:0] register_select,
    input wire logic       hostDataOe,
    // interrupt, port a and strobe
    input wire logic       irqOut,
    input wire logic       irqOe,
    input wire logic [7:0] portAOut,
    input wire logic [7:0] portAOe,
    input wire logic       port_b_strobe_n
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    // a selected read phase starts on the pins
    sequence s_rd_on;
        !(phi2 && !selN && rw) ##1 (phi2 && !selN && rw);
    endsequence
    AST_OE_RISE: assert property (s_rd_on |-> ##3 hostDataOe)
        else $error("data not driven on read");
    AST_OE_CAUSE: assert property (
        hostDataOe |-> $past(phi2 && !selN && rw, 3))
        else $error("data driven outside a read");
    AST_OE_DROP: assert property ($fell(phi2) |-> ##3 !hostDataOe)
        else $error("data still driven after read");
    AST_IRQ_LOW: assert property (irqOut == 1'b0)
        else $error("interrupt line driven high");
    AST_IRQ_CLEAR: assert property (
        $fell(irqOe) |-> $past(!selN && register_select == 4'hd, 5))
        else $error("interrupt dropped without access");
    AST_STROBE_CAUSE: assert property (
        $fell(port_b_strobe_n) |->
        $past(phi2 && !selN && register_select == 4'h1, 5))
        else $error("strobe without port b access");
    AST_DIR_CAUSE: assert property (
        $changed(portAOe) |->
        $past(!selN && !rw && register_select == 4'h2, 5))
        else $error("direction a changed without write");
    AST_DATA_CAUSE: assert property (
        $changed(portAOut) |->
        $past(!selN && !rw && register_select == 4'h0, 5))
        else $error("port a changed without write");
    AST_RESET: assert property (disable iff (1'b0)
        !nrst |=> portAOe == 8'h00 && !hostDataOe && port_b_strobe_n)
        else $error("outputs not cleared by reset");
endmodule
bind pit_top pit_props pit_props_inst (.sys_clk, .nrst, .phi2, .selN,
    .rw, .register_select, .hostDataOe, .irqOut, .irqOe, .portAOut,
    .portAOe, .port_b_strobe_n);

/* pit_host.sv */
// host model: one phi2 cycle per register access
`timescale 1ns/100ps
module pit_host (
    // clock
    input  wire logic         sysClk,
    // bus pins toward the device
    output pit_pkg::pit_bus_t bus,
    // resolved data bus
    input  wire logic [7:0]   wireData
);
    // idle bus: clock low, not selected
    initial bus = '{1'b0, 1'b1, 1'b1, 4'h0, 8'h00};
    // four cycles high, four low; data taken at end of high phase
    task automatic cyc(input logic sel, input logic rd,
                       input logic [3:0] rs, input logic [7:0] wd,
                       output logic [7:0] q);
        bus <= '{1'b1, !sel, rd, rs, rd ? ~bus.data : wd};
        repeat (4) @(negedge sysClk);
        q = wireData;
        bus.phi2 <= 1'b0;
        repeat (3) @(negedge sysClk);
        // released lines show the inverse of the last value
        bus <= '{1'b0, 1'b1, 1'b1, ~rs, ~bus.data};
        @(negedge sysClk);
    endtask
endmodule

/* test_parallel_io_and_interval_timers.sv */
// testbench: register table, then strobe, timer, flag and reset cases
`timescale 1ns/100ps
module test_parallel_io_and_interval_timers;
    localparam logic [7:0] BUS_CYC = 8'h08;  // sys clocks per host cycle
    logic sysClk = 1'b0, nrst = 1'b0;       // clock, reset
    logic flagN = 1'b1, cntIn = 1'b0;       // handshake and count pins
    pit_pkg::pit_bus_t bus;                 // host bus pins
    logic [7:0] dOut, aOut, aOe, bOut, bOe; // device outputs
    logic dOe, irqOut, irqOe, strobeN;
    logic [7:0] rd;                         // last read value
    wire [7:0] dWire = dOe ? dOut : bus.data;          // data bus
    wire [7:0] aPin = (aOe & aOut) | ~aOe;  // pull-ups where released
    wire [7:0] bPin = (bOe & bOut) | ~bOe;
    int n_mismatch = 0, checked = 0, lowLen = 0, lastLow = 0, i;
    // write one register, read one, expected value
    logic [23:0] rows [9] = '{
        24'h25a25a,  // direction a
        24'h00f0af,  // pins read back
        24'h33c33c,  // direction b
        24'h612600,  // write reaches latch only
        24'hf50f40,  // load strobe reads zero
        24'hf40612,  // forced load seen
        24'h877800,  // unmapped place
        24'he08e08,  // control a
        24'hf007ff}; // latch high all ones
    pit_top pit_top_inst (.sys_clk(sysClk), .nrst(nrst), .phi2(bus.phi2),
        .selN(bus.selN), .rw(bus.rw), .register_select(bus.regSel),
        .hostDataIn(dWire), .hostDataOut(dOut), .hostDataOe(dOe),
        .irqOut(irqOut), .irqOe(irqOe), .portAIn(aPin), .portAOut(aOut),
        .portAOe(aOe), .portBIn(bPin), .portBOut(bOut), .portBOe(bOe),
        .port_b_strobe_n(strobeN), .flagN(flagN), .count_input(cntIn));
    pit_host pit_host_inst (.sysClk(sysClk), .bus(bus), .wireData(dWire));
    initial begin
        forever #5 sysClk = ~sysClk;
    end
    // length of the last low pulse of the strobe
    always @(posedge sysClk) begin
        if (!strobeN) lowLen <= lowLen + 1;
        else if (lowLen != 0) begin
            lastLow <= lowLen;
            lowLen <= 0;
        end
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] r, input logic [7:0] d);
        pit_host_inst.cyc(1'b1, 1'b0, r, d, rd);
    endtask
    task automatic rdc(input logic [3:0] r, input logic [7:0] e);
        pit_host_inst.cyc(1'b1, 1'b1, r, 8'h00, rd);
        chk(rd, e);
    endtask
    // unselected write cycles keep the bus clock running
    task automatic idle(input int n);
        repeat (n) pit_host_inst.cyc(1'b0, 1'b0, 4'h0, 8'hee, rd);
    endtask
    task automatic results();
        $display("mismatches %0d checks %0d", n_mismatch, checked);
        if (n_mismatch == 0 && checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // hang guard
    initial begin
        repeat (20000) @(posedge sysClk);
        n_mismatch++;
        results();
    end
    initial begin
        repeat (10) @(negedge sysClk);
        nrst = 1'b1;
        repeat (4) @(negedge sysClk);
        chk(aOe, 8'h00);
        rdc(4'h3, 8'h00);
        rdc(4'h5, 8'h00);
        foreach (rows[j]) begin
            wr(rows[j][23:20], rows[j][19:12]);
            rdc(rows[j][11:8], rows[j][7:0]);
        end
        idle(1);
        chk(aOut, 8'h0f);
        // word transfer: port a first, port b strobes
        wr(4'h0, 8'h0f);
        wr(4'h1, 8'h81);
        idle(2);
        chk(lastLow[7:0], BUS_CYC);
        rdc(4'h1, 8'hc3);
        chk({7'h00, strobeN}, 8'h00);
        idle(2);
        chk(lastLow[7:0], BUS_CYC);
        // timer a one-shot on bus cycles
        wr(4'hd, 8'h81);
        wr(4'h4, 8'h03);
        wr(4'h5, 8'h00);
        rdc(4'h4, 8'h03);
        wr(4'he, 8'h09);
        idle(6);
        chk({7'h00, irqOe}, 8'h01);
        rdc(4'he, 8'h08);
        rdc(4'h4, 8'h03);
        rdc(4'hd, 8'h81);
        idle(1);
        chk({7'h00, irqOe}, 8'h00);
        // toggle output forced onto line six
        wr(4'he, 8'h07);
        chk({6'h00, bOe[6], bOut[6]}, 8'h03);
        wr(4'he, 8'h00);
        chk({7'h00, bOe[6]}, 8'h00);
        // pulse output, running high write, continuous reload
        wr(4'he, 8'h03);
        wr(4'h5, 8'h01);
        rdc(4'h4, 8'h01);
        rdc(4'h5, 8'h00);
        chk({6'h00, bOe[6], bOut[6]}, 8'h03);
        rdc(4'h5, 8'h01);
        chk({7'h00, bOut[6]}, 8'h00);
        rdc(4'he, 8'h03);
        wr(4'he, 8'h00);
        rdc(4'h4, 8'h00);
        rdc(4'hd, 8'h81);
        rdc(4'h4, 8'h00);
        // timer b counts count pin pulses
        wr(4'h6, 8'h05);
        wr(4'h7, 8'h00);
        wr(4'hf, 8'h21);
        repeat (2) begin
            cntIn = 1'b1;
            repeat (4) @(negedge sysClk);
            cntIn = 1'b0;
            repeat (4) @(negedge sysClk);
        end
        wr(4'hf, 8'h20);
        rdc(4'h6, 8'h03);
        // handshake input: fall sets flag, rise does not
        wr(4'hd, 8'h90);
        flagN = 1'b0;
        for (i = 0; i < 40 && irqOe !== 1'b1; i++) @(negedge sysClk);
        chk({7'h00, irqOe}, 8'h01);
        rdc(4'hd, 8'h90);
        flagN = 1'b1;
        idle(1);
        rdc(4'hd, 8'h00);
        // second reset in mid-run
        nrst = 1'b0;
        repeat (2) @(negedge sysClk);
        chk(bOe, 8'h00);
        chk({7'h00, strobeN}, 8'h01);
        nrst = 1'b1;
        repeat (4) @(negedge sysClk);
        rdc(4'hf, 8'h00);
        results();
    end
endmodule
